// ### design/msgq_pkg.sv
// Package: register map, field layout, queue codes and bus types
package msgq_pkg;
   // ==========================================================
   // Register map (byte addresses on the AXI4-Lite port)
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_STATUS   = 8'h04;
   localparam logic [7:0] A_QBASE    = 8'h08;
   localparam logic [7:0] A_QSIZE    = 8'h0C;
   localparam logic [7:0] A_PTR0     = 8'h20; // Eight pointers, 4 apart
   // Control bits
   localparam int CTL_MSG_EN   = 0;
   localparam int CTL_PCI_ACCESS_DISABLE  = 1;
   localparam int CTL_LIRQ_EN  = 2;
   localparam int CTL_PIRQ_EN  = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0002;
   // Status bits
   localparam int ST_NEW_ENTRY = 0;
   localparam int ST_OP_NE     = 1;
   localparam int ST_EMPTY0    = 8;  // Empty flags 8..11
   localparam int ST_FULL0     = 12; // Full flags 12..15
   // ==========================================================
   // Pointer indices: top/bottom per queue
   localparam int P_IF_BOT = 0;
   localparam int P_IF_TOP = 1;
   localparam int P_IP_BOT = 2;
   localparam int P_IP_TOP = 3;
   localparam int P_OP_BOT = 4;
   localparam int P_OP_TOP = 5;
   localparam int P_OF_BOT = 6;
   localparam int P_OF_TOP = 7;
   // Queue indices
   localparam int Q_IF = 0;
   localparam int Q_IP = 1;
   localparam int Q_OP = 2;
   localparam int Q_OF = 3;
   // ==========================================================
   // PCI-side decode of the messaging window
   localparam logic [11:0] PO_IRQ0   = 12'h030;
   localparam logic [11:0] PO_IRQ1   = 12'h034;
   localparam logic [11:0] PO_INQ    = 12'h040;
   localparam logic [11:0] PO_OUTQ   = 12'h044;
   localparam logic [7:0]  CFG_BAR0  = 8'h10;
   localparam logic [7:0]  CFG_BAR2  = 8'h18;
   localparam logic [31:0] EMPTY_VAL = 32'hFFFF_FFFF;
   localparam int WIN_BITS   = 20; // 1 Mbyte window
   localparam int UNTR_BITS  = 12; // 4 Kbyte untranslated
   localparam logic [19:0] PTR_STEP = 20'h00004;
   // Response codes
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   // ==========================================================
   // Local memory request carrier
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
      logic [31:0] data;
   } mem_req_t;
endpackage : msgq_pkg

// ### design/msgq_ring.sv
// One circular queue: occupancy, full flag and pointer stepping
`timescale 1ns/10ps
module msgq_ring
   import msgq_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Software pointer writes
   input  wire logic        sw_top_we,
   input  wire logic        sw_bot_we,
   input  wire logic [19:0] sw_val,
   // Hardware advance requests
   input  wire logic        hw_push,
   input  wire logic        hw_pop,
   // Queue size mask (size minus one, bytes)
   input  wire logic [19:0] size_mask,
   // State
   output logic      [19:0] top_r,
   output logic      [19:0] bot_r,
   output logic             empty,
   output logic             full
);
   logic        full_r;
   logic [19:0] top_nxt;
   logic [19:0] bot_nxt;

   // Modulo step inside the aligned queue
   assign top_nxt = (top_r & ~size_mask) | ((top_r + PTR_STEP) & size_mask);
   assign bot_nxt = (bot_r & ~size_mask) | ((bot_r + PTR_STEP) & size_mask);
   assign full  = full_r;
   assign empty = (top_r == bot_r) && !full_r;

   // ==========================================================
   // Pointers
   always_ff @(posedge clk) begin
      if (srst) begin
         top_r <= 20'h00000;
         bot_r <= 20'h00000;
      end else begin
         if (sw_top_we)
            top_r <= sw_val;
         else if (hw_push && !full_r)
            top_r <= top_nxt;
         if (sw_bot_we)
            bot_r <= sw_val;
         else if (hw_pop && !empty)
            bot_r <= bot_nxt;
      end
   end

   // Full flag: set when a top step meets the bottom
   always_ff @(posedge clk) begin
      if (srst)
         full_r <= 1'b0;
      else if (sw_top_we)
         full_r <= (sw_val == bot_r) && (sw_val == top_nxt);
      else if (hw_push && !full_r)
         full_r <= (top_nxt == bot_r);
      else if ((hw_pop && !empty) || sw_bot_we)
         full_r <= 1'b0;
   end
endmodule // msgq_ring

// ### design/msgq_axil.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/10ps
module msgq_axil
   import msgq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   // AXI4-Lite
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Register side
   output logic             wr_stb,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_ok,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_ok
);
   logic aw_h_r, w_h_r;

   assign awready = !aw_h_r && !bvalid;
   assign wready  = !w_h_r && !bvalid;
   assign arready = !rvalid;
   assign wr_stb  = aw_h_r && w_h_r && !bvalid;
   assign rd_addr = araddr;

   // Capture address and data in either order
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_h_r  <= 1'b0;
         w_h_r   <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OK;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_h_r  <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_h_r   <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_stb) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OK : RESP_ERR;
            aw_h_r <= 1'b0;
            w_h_r  <= 1'b0;
         end else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Reads answer one cycle after the address
   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OK;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rd_ok ? rd_data : 32'h0000_0000;
         rresp  <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (rvalid && rready)
         rvalid <= 1'b0;
   end
endmodule // msgq_axil

// ### design/msgq_unit.sv
// Message queue unit: four frame-address queues in local memory
// How it works
// - Four local-memory queues: in free, in post, out post/free
// - Top and bottom pointer each, eight registers
// - Pointers offset from 1 Mbyte aligned base
// - Inbound port write posts, local interrupt
// - Inbound port read pops free, empty gives ones
// - Outbound port read pops post, empty ones
// - Outbound port write stores at free top
// - PCI interrupt when outbound post holds entries
// - Messaging enable moves base registers 0x010/0x018
// - Lowest 4K untranslated, rest via image 0
// - Decode 0x030/0x034 interrupts, 0x040/0x044 ports
// - Outbound addresses are absolute host offsets
// - Equal pointers at start mean empty
// - Outbound port write advances free top
// - Hardware pointers step four, wrap modulo size
// - No top step full, no bottom step empty
// - New post sets status, write one clears
`timescale 1ns/10ps
module msgq_unit
   import msgq_pkg::*;
#(
   parameter int unsigned QSIZE_RST = 20'h00400
)(
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        SRST,
   // AXI4-Lite register port
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // PCI target request (one cycle strobe)
   input  wire logic        PCI_REQ,
   input  wire logic        PCI_WR,
   input  wire logic [31:0] PCI_OFFS,
   input  wire logic [31:0] PCI_WDATA,
   // PCI target answer
   output logic             PCI_DONE,
   output logic             PCI_RETRY,
   output logic [31:0]      PCI_RDATA,
   output logic             PCI_XLATE,
   output logic             PCI_SYSIRQ,
   output logic [1:0]       PCI_SYSIRQ_SEL,
   // Configuration map view
   output logic [7:0]       CFG_MSG_BAR_OFFS,
   output logic [7:0]       CFG_REG_BAR_OFFS,
   output logic             PCI_ACCESS_DISABLE,
   // Local bus memory master
   output logic             MEM_REQ,
   output mem_req_t         MEM_CMD,
   input  wire logic        MEM_ACK,
   input  wire logic [31:0] MEM_RDATA,
   // Interrupts
   output logic             LOCAL_IRQ,
   output logic             PCI_IRQ
);
   // ==========================================================
   // Declarations
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_RD   = 4'b0010,
      S_WR   = 4'b0100,
      S_HOLD = 4'b1000
   } state_t;

   state_t      state_r;
   logic [31:0] ctrl_r;
   logic [11:0] qbase_r;
   logic [19:0] qsize_r;
   logic        new_entry_r;
   logic [31:0] hold_data_r;
   logic [1:0]  op_q_r;       // Queue of the pending access
   logic [11:0] pend_offs_r;

   logic        wr_stb, wr_ok, rd_ok;
   logic [7:0]  wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0]  wr_strb;
   logic [19:0] size_mask;
   logic [19:0] top   [4];
   logic [19:0] bot   [4];
   logic [3:0]  q_empty, q_full;
   logic [3:0]  q_push, q_pop;
   logic [7:0]  sw_pwe;
   logic        msg_en, port_hit, in_port, out_port;

   assign msg_en    = ctrl_r[CTL_MSG_EN];
   assign size_mask = qsize_r - 20'h00001;
   assign port_hit  = PCI_REQ && msg_en && !ctrl_r[CTL_PCI_ACCESS_DISABLE]
                      && (PCI_OFFS[31:UNTR_BITS] == '0);
   assign in_port   = port_hit && (PCI_OFFS[11:0] == PO_INQ);
   assign out_port  = port_hit && (PCI_OFFS[11:0] == PO_OUTQ);

   // ==========================================================
   // Register port
   msgq_axil u_axil (
      .clk     (MCLK),
      .srst    (SRST),
      .awaddr  (AWADDR),
      .awvalid (AWVALID),
      .awready (AWREADY),
      .wdata   (WDATA),
      .wstrb   (WSTRB),
      .wvalid  (WVALID),
      .wready  (WREADY),
      .bresp   (BRESP),
      .bvalid  (BVALID),
      .bready  (BREADY),
      .araddr  (ARADDR),
      .arvalid (ARVALID),
      .arready (ARREADY),
      .rdata   (RDATA),
      .rresp   (RRESP),
      .rvalid  (RVALID),
      .rready  (RREADY),
      .wr_stb  (wr_stb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // ==========================================================
   // Four queues, one ring each
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_q
         msgq_ring u_ring (
            .clk       (MCLK),
            .srst      (SRST),
            .sw_top_we (sw_pwe[2*g+1]),
            .sw_bot_we (sw_pwe[2*g]),
            .sw_val    (wr_data[19:0]),
            .hw_push   (q_push[g]),
            .hw_pop    (q_pop[g]),
            .size_mask (size_mask),
            .top_r     (top[g]),
            .bot_r     (bot[g]),
            .empty     (q_empty[g]),
            .full      (q_full[g])
         );
      end
      for (g = 0; g < 8; g++) begin : g_we
         // Software writes of the eight pointers
         assign sw_pwe[g] = wr_stb && (wr_addr == A_PTR0 + 8'(4*g))
                            && (wr_strb == 4'hF);
      end
   endgenerate

   // Hardware steps once the memory access completes
   always_comb begin
      q_push = 4'h0;
      q_pop  = 4'h0;
      if (MEM_ACK && (state_r == S_RD || state_r == S_WR)) begin
         if (state_r == S_WR)
            q_push[op_q_r] = 1'b1;
         else
            q_pop[op_q_r] = 1'b1;
      end
   end

   // ==========================================================
   // Register writes: control, base, size, status clear
   assign wr_ok = (wr_addr[1:0] == 2'b00)
                  && (wr_addr <= A_QSIZE || wr_addr[7:5] == 3'b001);
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_r  <= CTRL_RST;
         qbase_r <= 12'h000;
         qsize_r <= 20'(QSIZE_RST);
      end else if (wr_stb) begin
         case (wr_addr)
            A_CTRL:  ctrl_r  <= wr_data & 32'h0000_000F;
            A_QBASE: qbase_r <= wr_data[31:WIN_BITS];
            A_QSIZE: qsize_r <= wr_data[19:0];
            default: ;
         endcase
      end
   end

   // New-entry status: set wins over a write-one clear
   always_ff @(posedge MCLK) begin
      if (SRST)
         new_entry_r <= 1'b0;
      else if (q_push[Q_IP])
         new_entry_r <= 1'b1;
      else if (wr_stb && wr_addr == A_STATUS && wr_data[ST_NEW_ENTRY])
         new_entry_r <= 1'b0;
   end

   // Register read mux
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      case (rd_addr)
         A_CTRL:   rd_data = ctrl_r;
         A_STATUS: begin
            rd_data[ST_NEW_ENTRY] = new_entry_r;
            rd_data[ST_OP_NE]     = !q_empty[Q_OP];
            rd_data[ST_EMPTY0+:4] = q_empty;
            rd_data[ST_FULL0+:4]  = q_full;
         end
         A_QBASE:  rd_data = {qbase_r, 20'h00000};
         A_QSIZE:  rd_data = {12'h000, qsize_r};
         default: begin
            if (rd_addr[7:5] == 3'b001 && rd_addr[1:0] == 2'b00)
               rd_data = {qbase_r, rd_addr[2] ? top[rd_addr[4:3]]
                                              : bot[rd_addr[4:3]]};
            else
               rd_ok = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // PCI port sequencer: delayed reads, posted writes
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state_r     <= S_IDLE;
         op_q_r      <= 2'd0;
         hold_data_r <= 32'h0000_0000;
         pend_offs_r <= 12'h000;
         MEM_REQ     <= 1'b0;
         MEM_CMD     <= '0;
         PCI_DONE    <= 1'b0;
         PCI_RETRY   <= 1'b0;
         PCI_RDATA   <= 32'h0000_0000;
      end else begin
         PCI_DONE  <= 1'b0;
         PCI_RETRY <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if ((in_port || out_port) && !PCI_WR) begin
                  op_q_r      <= in_port ? 2'(Q_IF) : 2'(Q_OP);
                  pend_offs_r <= PCI_OFFS[11:0];
                  PCI_RETRY   <= 1'b1;
                  if (q_empty[in_port ? Q_IF : Q_OP]) begin
                     hold_data_r <= EMPTY_VAL;
                     state_r     <= S_HOLD;
                  end else begin
                     MEM_REQ <= 1'b1;
                     MEM_CMD <= '{wr: 1'b0, addr: {qbase_r,
                        in_port ? bot[Q_IF] : bot[Q_OP]}, data: '0};
                     state_r <= S_RD;
                  end
               end else if ((in_port || out_port) && PCI_WR) begin
                  op_q_r   <= in_port ? 2'(Q_IP) : 2'(Q_OF);
                  PCI_DONE <= 1'b1; // Posted write
                  if (!q_full[in_port ? Q_IP : Q_OF]) begin
                     MEM_REQ <= 1'b1;
                     MEM_CMD <= '{wr: 1'b1, addr: {qbase_r,
                        in_port ? top[Q_IP] : top[Q_OF]},
                        data: PCI_WDATA};
                     state_r <= S_WR;
                  end
               end else if (PCI_REQ) begin
                  PCI_DONE <= 1'b1; // Other offsets end at once
               end
            end
            S_RD: begin
               if (PCI_REQ)
                  PCI_RETRY <= 1'b1;
               if (MEM_ACK) begin
                  MEM_REQ     <= 1'b0;
                  hold_data_r <= MEM_RDATA;
                  state_r     <= S_HOLD;
               end
            end
            S_WR: begin
               if (PCI_REQ)
                  PCI_RETRY <= 1'b1; // Busy, master retries
               if (MEM_ACK) begin
                  MEM_REQ <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            S_HOLD: begin
               if (PCI_REQ && !PCI_WR
                   && PCI_OFFS[11:0] == pend_offs_r) begin
                  PCI_RDATA <= hold_data_r;
                  PCI_DONE  <= 1'b1;
                  state_r   <= S_IDLE;
               end else if (PCI_REQ)
                  PCI_RETRY <= 1'b1;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Decode flags and interrupts, all registered
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         PCI_XLATE          <= 1'b0;
         PCI_SYSIRQ         <= 1'b0;
         PCI_SYSIRQ_SEL     <= 2'b00;
         CFG_MSG_BAR_OFFS   <= 8'h00;
         CFG_REG_BAR_OFFS   <= CFG_BAR0;
         PCI_ACCESS_DISABLE <= 1'b1;
         LOCAL_IRQ          <= 1'b0;
         PCI_IRQ            <= 1'b0;
      end else begin
         // Offsets above 4K go through image 0
         PCI_XLATE <= PCI_REQ && msg_en
                      && (PCI_OFFS[31:UNTR_BITS] != '0);
         PCI_SYSIRQ <= port_hit && PCI_WR
                       && (PCI_OFFS[11:0] == PO_IRQ0
                           || PCI_OFFS[11:0] == PO_IRQ1);
         PCI_SYSIRQ_SEL <= {PCI_OFFS[11:0] == PO_IRQ1,
                            PCI_OFFS[11:0] == PO_IRQ0};
         CFG_MSG_BAR_OFFS <= msg_en ? CFG_BAR0 : 8'h00;
         CFG_REG_BAR_OFFS <= msg_en ? CFG_BAR2 : CFG_BAR0;
         PCI_ACCESS_DISABLE <= ctrl_r[CTL_PCI_ACCESS_DISABLE];
         LOCAL_IRQ <= ctrl_r[CTL_LIRQ_EN] && new_entry_r;
         PCI_IRQ   <= ctrl_r[CTL_PIRQ_EN] && !q_empty[Q_OP];
      end
   end
endmodule // msgq_unit

// ### tb/msgq_unit_properties.sv
// Port checker for the message queue unit
`timescale 1ns/10ps
module msgq_unit_properties
   import msgq_pkg::*;
(
   // Clock, reset and PCI side
   input wire logic        MCLK,
   input wire logic        SRST,
   input wire logic        PCI_REQ,
   input wire logic        PCI_WR,
   input wire logic [31:0] PCI_OFFS,
   input wire logic [31:0] PCI_WDATA,
   input wire logic        PCI_DONE,
   input wire logic        PCI_RETRY,
   input wire logic        PCI_XLATE,
   input wire logic        PCI_SYSIRQ,
   input wire logic [1:0]  PCI_SYSIRQ_SEL,
   input wire logic [7:0]  CFG_MSG_BAR_OFFS,
   input wire logic [7:0]  CFG_REG_BAR_OFFS,
   input wire logic        PCI_ACCESS_DISABLE,
   // Local memory side
   input wire logic        MEM_REQ,
   input wire mem_req_t    MEM_CMD,
   input wire logic        MEM_ACK
);
   // ========
   // Helpers
   logic on;
   // Messaging window live
   assign on = CFG_MSG_BAR_OFFS == CFG_BAR0;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   // ========
   // Assertions
   a_mem_hold: assert property (MEM_REQ && !MEM_ACK
      |=> MEM_REQ && $stable(MEM_CMD)) else $error("memory request dropped");
   a_bar_move: assert property (
      CFG_REG_BAR_OFFS == (on ? CFG_BAR2 : CFG_BAR0))
      else $error("register base slot wrong");
   a_answer_next: assert property (
      PCI_REQ && on && !PCI_ACCESS_DISABLE && PCI_OFFS < 32'h1000
      |=> PCI_DONE || PCI_RETRY) else $error("request unanswered");
   a_answer_cause: assert property (PCI_DONE || PCI_RETRY
      |-> $past(PCI_REQ)) else $error("answer without request");
   a_sys_sel: assert property (PCI_SYSIRQ |-> $past(PCI_REQ && PCI_WR)
      && PCI_SYSIRQ_SEL == {$past(PCI_OFFS[11:0]) == PO_IRQ1,
      $past(PCI_OFFS[11:0]) == PO_IRQ0}) else $error("bad system irq");
   a_xlate_hi: assert property (PCI_XLATE
      |-> $past(PCI_REQ && on && PCI_OFFS >= 32'h1000))
      else $error("translation below window");
   a_wdata_pass: assert property ($rose(MEM_REQ) && MEM_CMD.wr
      |-> MEM_CMD.data == $past(PCI_WDATA) && $past(PCI_REQ && PCI_WR))
      else $error("memory write data wrong");
   a_rd_retry: assert property ($rose(MEM_REQ) && !MEM_CMD.wr
      |-> PCI_RETRY) else $error("read not retried");
   // Main scenarios
   c_mem_read: cover property (MEM_ACK && !MEM_CMD.wr);
   c_sysirq: cover property (PCI_SYSIRQ);
   c_xlate: cover property (PCI_XLATE);
endmodule // msgq_unit_properties

bind msgq_unit msgq_unit_properties msgq_unit_properties_inst (.MCLK, .SRST,
   .PCI_REQ, .PCI_WR, .PCI_OFFS, .PCI_WDATA, .PCI_DONE, .PCI_RETRY,
   .PCI_XLATE, .PCI_SYSIRQ, .PCI_SYSIRQ_SEL, .CFG_MSG_BAR_OFFS,
   .CFG_REG_BAR_OFFS, .PCI_ACCESS_DISABLE, .MEM_REQ, .MEM_CMD, .MEM_ACK);

// ### tb/lb_mem_model.sv
// Local-bus memory model answering the unit's memory requests
`timescale 1ns/10ps
module lb_mem_model
   import msgq_pkg::*;
(
   // Request
   input  wire logic     clk,
   input  wire logic     req,
   input  wire mem_req_t cmd,
   // Answer
   output logic          ack = 1'b0,
   output logic [31:0]   rdata = 32'h0
);
   // ========
   // Storage, preloaded by the bench
   logic [31:0] mem [logic [31:0]];
   int          cnt = 0;
   int          n_acc = 0;
   // Alternate quick and slow answers; idle data toggles
   always @(posedge clk) begin
      if (ack) begin
         ack <= 1'b0;
         rdata <= ~rdata;
      end else if (req) begin
         cnt <= cnt + 1;
         if (cnt >= (n_acc[0] ? 6 : 1)) begin
            ack <= 1'b1;
            cnt <= 0;
            n_acc <= n_acc + 1;
            if (cmd.wr)
               mem[cmd.addr] = cmd.data;
            else
               rdata <= mem.exists(cmd.addr) ? mem[cmd.addr] : 32'hA5A5_A5A5;
         end
      end else
         rdata <= ~rdata;
   end
endmodule // lb_mem_model

// ### tb/msgq_unit_tb.sv
// Bench for the message queue unit
`timescale 1ns/10ps
module msgq_unit_tb
   import msgq_pkg::*;
;
   // ========
   // Signals
   localparam logic [31:0] QB = 32'hA000_0000;
   logic MCLK = 1'b0, SRST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0;
   logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, PCI_REQ = 1'b0;
   logic PCI_WR = 1'b0, AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_ACK;
   logic PCI_DONE, PCI_RETRY, PCI_XLATE, PCI_SYSIRQ, PCI_ACCESS_DISABLE;
   logic MEM_REQ, LOCAL_IRQ, PCI_IRQ, pdone, pxl;
   logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
   logic [7:0]  CFG_MSG_BAR_OFFS, CFG_REG_BAR_OFFS;
   logic [3:0]  WSTRB = 4'hF;
   logic [1:0]  BRESP, RRESP, PCI_SYSIRQ_SEL, rr;
   logic [2:0]  psys;
   logic [31:0] WDATA = 32'h0, PCI_OFFS = 32'h0, PCI_WDATA = 32'h0;
   logic [31:0] RDATA, PCI_RDATA, MEM_RDATA, prd, rd;
   mem_req_t    MEM_CMD;
   int          num_errors = 0;
   int          compares = 0;
   // 25 MHz clock
   always #20 MCLK = ~MCLK;
   msgq_unit msgq_unit_inst (.MCLK, .SRST, .AWADDR, .AWVALID, .AWREADY,
      .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
      .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PCI_REQ,
      .PCI_WR, .PCI_OFFS, .PCI_WDATA, .PCI_DONE, .PCI_RETRY, .PCI_RDATA,
      .PCI_XLATE, .PCI_SYSIRQ, .PCI_SYSIRQ_SEL, .CFG_MSG_BAR_OFFS,
      .CFG_REG_BAR_OFFS, .PCI_ACCESS_DISABLE, .MEM_REQ, .MEM_CMD, .MEM_ACK,
      .MEM_RDATA, .LOCAL_IRQ, .PCI_IRQ);
   lb_mem_model lb_mem_model_inst (.clk(MCLK), .req(MEM_REQ),
      .cmd(MEM_CMD), .ack(MEM_ACK), .rdata(MEM_RDATA));
   // ========
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Ready sampled mid-cycle
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, bv;
      bv = 1'b0;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!bv) begin
         @(negedge MCLK);
         ah = AWREADY;
         wh = WREADY;
         bv = BVALID;
         @(posedge MCLK);
         if (ah) AWVALID <= 1'b0;
         if (wh) WVALID <= 1'b0;
      end
      BREADY <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      logic ah, rv;
      rv = 1'b0;
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!rv) begin
         @(negedge MCLK);
         ah = ARREADY;
         rv = RVALID;
         rd = RDATA;
         rr = RRESP;
         @(posedge MCLK);
         if (ah) ARVALID <= 1'b0;
      end
      RREADY <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(rd, e);
   endtask
   // Retries spaced four cycles apart until done or translated, at most 40 tries
   task automatic pci(input logic w, input logic [31:0] o, d);
      int n = 0;
      pdone = 1'b0;
      pxl = 1'b0;
      while (!pdone && !pxl && n < 40) begin
         @(posedge MCLK);
         PCI_REQ <= 1'b1;
         PCI_WR <= w;
         PCI_OFFS <= o;
         PCI_WDATA <= d;
         @(posedge MCLK);
         PCI_REQ <= 1'b0;
         #1;
         pdone = PCI_DONE;
         prd = PCI_RDATA;
         pxl = PCI_XLATE;
         psys = {PCI_SYSIRQ, PCI_SYSIRQ_SEL};
         n++;
         repeat (2) @(posedge MCLK);
      end
      if (!pdone && !pxl) num_errors++;
   endtask
   task automatic mwait;
      int n = 0;
      while (MEM_REQ !== 1'b0 && n < 50) begin
         @(posedge MCLK);
         n++;
      end
      if (n >= 50) num_errors++;
      #1;
   endtask
   // ========
   // Scenarios
   task automatic t_reset;
      chk(CFG_REG_BAR_OFFS, 8'h10);
      chk(PCI_ACCESS_DISABLE, 1'b1);
      rchk(A_CTRL, CTRL_RST);
      rchk(A_QSIZE, 32'h400);
      axr(8'hF0);
      chk(rr, RESP_ERR);
   endtask
   task automatic t_init;
      for (int i = 0; i < 3; i++)
         lb_mem_model_inst.mem[QB + 4 * i] = 32'h2000 + 32'h100 * i;
      lb_mem_model_inst.mem[QB + 32'h1000] = 32'h4000;
      axw(A_QBASE, QB);
      for (int i = 2; i < 8; i++)
         axw(A_PTR0 + 8'(4 * i), 32'(i / 2) * 32'h800);
      axw(A_PTR0 + 8'h04, 32'h0C);
      axw(A_CTRL, 32'h0000_000D);
      @(posedge MCLK);
      #1;
      chk(CFG_MSG_BAR_OFFS, 8'h10);
      chk(CFG_REG_BAR_OFFS, 8'h18);
      rchk(A_PTR0 + 8'h0C, QB | 32'h800);
   endtask
   task automatic t_in_free;
      for (int i = 0; i < 3; i++) begin
         pci(1'b0, 32'h040, 32'h0);
         chk(prd, 32'h2000 + 32'h100 * i);
      end
      pci(1'b0, 32'h040, 32'h0);
      chk(prd, EMPTY_VAL);
      rchk(A_PTR0, QB | 32'h0C);
   endtask
   task automatic t_in_post;
      pci(1'b1, 32'h040, 32'h2000);
      mwait();
      chk(lb_mem_model_inst.mem[QB + 32'h800], 32'h2000);
      rchk(A_PTR0 + 8'h0C, QB | 32'h804);
      chk(LOCAL_IRQ, 1'b1);
      axr(A_STATUS);
      chk(rd[0], 1'b1);
      axw(A_STATUS, 32'h1);
      @(posedge MCLK);
      #1;
      chk(LOCAL_IRQ, 1'b0);
   endtask
   task automatic t_out;
      pci(1'b1, 32'h044, 32'h3000);
      mwait();
      chk(lb_mem_model_inst.mem[QB + 32'h1800], 32'h3000);
      rchk(A_PTR0 + 8'h1C, QB | 32'h1804);
      chk(PCI_IRQ, 1'b0);
      axw(A_PTR0 + 8'h14, 32'h1004);
      @(posedge MCLK);
      #1;
      chk(PCI_IRQ, 1'b1);
      pci(1'b0, 32'h044, 32'h0);
      chk(prd, 32'h4000);
      chk(PCI_IRQ, 1'b0);
      pci(1'b0, 32'h044, 32'h0);
      chk(prd, EMPTY_VAL);
   endtask
   task automatic t_decode;
      pci(1'b1, 32'h030, 32'h0);
      chk(psys, 3'b101);
      pci(1'b1, 32'h034, 32'h0);
      chk(psys, 3'b110);
      pci(1'b0, 32'h2000, 32'h0);
      chk(pxl, 1'b1);
   endtask
   // ========
   // Verdict and main sequence
   task automatic test_done;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge MCLK);
      SRST <= 1'b0;
      #1;
      t_reset();
      t_init();
      t_in_free();
      t_in_post();
      t_out();
      t_decode();
      test_done();
   end
   // Hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge MCLK);
      num_errors++;
      test_done();
   end
endmodule // msgq_unit_tb
